// ===== bench/eight_bit_timer_event_counter_bench.sv
// Self-checking bench for the dual timer
`timescale 1ns/1ps
module eight_bit_timer_event_counter_bench
	import timer_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic rdp = 1'b0;
	logic [1:0] htrans, ev, tout, mint;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] q[$];
	int mismatches, samples_checked;
	int sh[2][6] = '{'{0, 1, 2, 6, 8, 13}, '{0, 1, 4, 6, 8, 12}};
	timer_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .event_input(ev), .timer_output(tout),
		.match_interrupt(mint));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wait_for(int c, logic m, logic lv, output int n);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while ((m ? mint[c] : tout[c]) !== lv && n < 40000);
		if ((m ? mint[c] : tout[c]) !== lv) begin
			mismatches++;
			$display("[ERR] %0t pin wait timed out", $time);
			report_and_stop();
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t bus wait timed out", $time);
			report_and_stop();
		end
	endtask
	// Single word transfer; on a read d is the expected value
	task automatic bus(logic w, logic [31:0] a, logic [7:0] d);
		@(posedge hclk);
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= a;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		if (!w) q.push_back(d);
		wait_rdy();
	endtask
	task automatic width(int c, logic lv, int exp);
		int n;
		wait_for(c, 0, !lv, n);
		wait_for(c, 0, lv, n);
		wait_for(c, 0, !lv, n);
		check(n, exp);
	endtask
	// Read data monitor
	always @(posedge hclk) begin
		if (hreadyout) begin
			if (rdp) check(hrdata, {24'h0, q.pop_front()});
			rdp <= hsel && htrans[1] && !hwrite;
		end
	end
	initial begin
		int c, s, n;
		logic [7:0] v;
		mismatches = 0;
		samples_checked = 0;
		hresetn = 1'b0;
		hsel = 1'b1;
		hsize = 3'h2;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = '0;
		hwdata = '0;
		ev = 2'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		void'($urandom(32'h5cc0));
		for (c = 0; c < 2; c++) begin
			bus(0, ADDR_COUNTER[c], 8'h00);
			bus(0, ADDR_COMPARE[c], 8'h00);
			bus(0, ADDR_SELECT[c], 8'h00);
			v = 8'($urandom);
			bus(1, ADDR_COMPARE[c], v);
			bus(0, ADDR_COMPARE[c], v);
			bus(1, ADDR_MODE[c], 8'h0E);
			bus(0, ADDR_MODE[c], 8'h02);
		end
		bus(0, 32'h0000_0010, 8'h00);
		for (c = 0; c < 2; c++) begin
			for (s = 2; s < 8; s++) begin
				bus(1, ADDR_MODE[c], 8'h00);
				bus(1, ADDR_SELECT[c], 8'(s));
				bus(1, ADDR_COMPARE[c], 8'h01);
				bus(1, ADDR_MODE[c], 8'h80);
				wait_for(c, 1, 1, n);
				wait_for(c, 1, 1, n);
				check(n, 2 << sh[c][s-2]);
			end
		end
		for (c = 0; c < 2; c++) begin
			v = 8'(1 + $urandom % 100);
			bus(1, ADDR_MODE[c], 8'h00);
			bus(1, ADDR_SELECT[c], 8'(SEL_DIV1));
			bus(1, ADDR_COMPARE[c], v);
			bus(1, ADDR_MODE[c], 8'h83);
			width(c, 1, v + 1);
			bus(1, ADDR_MODE[c], 8'h00);
			bus(0, ADDR_COUNTER[c], 8'h00);
			bus(1, ADDR_MODE[c], 8'hC1);
			width(c, 1, v + 1);
			width(c, 0, 255 - v);
			bus(1, ADDR_MODE[c], 8'h00);
			bus(1, ADDR_MODE[c], 8'hC3);
			width(c, 0, v + 1);
			bus(1, ADDR_MODE[c], 8'h00);
		end
		bus(1, ADDR_MODE[0], 8'h05);
		wait_for(0, 0, 0, n);
		bus(1, ADDR_MODE[0], 8'h09);
		wait_for(0, 0, 1, n);
		check(32'(n <= 4), 32'h1);
		bus(1, ADDR_MODE[0], 8'h0D);
		repeat (4) @(posedge hclk);
		@(negedge hclk);
		check(tout[0], 1'b1);
		bus(1, ADDR_MODE[0], 8'h05);
		wait_for(0, 0, 0, n);
		check(32'(n <= 4), 32'h1);
		bus(1, ADDR_MODE[0], 8'h08);
		repeat (4) @(posedge hclk);
		@(negedge hclk);
		check(tout[0], 1'b0);
		for (c = 0; c < 2; c++) begin
			for (s = 0; s < 2; s++) begin
				v = 8'(1 + $urandom % 8);
				bus(1, ADDR_MODE[c], 8'h00);
				bus(1, ADDR_SELECT[c], 8'(s));
				bus(1, ADDR_COMPARE[c], 8'hFF);
				bus(1, ADDR_MODE[c], 8'h80);
				repeat (v) begin
					ev[c] <= 1'b1;
					repeat (4) @(posedge hclk);
					ev[c] <= 1'b0;
					repeat (4) @(posedge hclk);
				end
				bus(0, ADDR_COUNTER[c], v);
			end
		end
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, ADDR_COUNTER[1], 8'h00);
		bus(0, ADDR_COMPARE[1], 8'h00);
		bus(0, ADDR_SELECT[1], 8'h00);
		repeat (4) @(posedge hclk);
		report_and_stop();
	end
endmodule

// ===== bench/timer_top_sva.sv
// Assertion checker for the timer bus and pins
`timescale 1ns/1ps
module timer_sva
	import timer_pkg::*;
(
	// Bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins
	input wire logic [CHANNELS-1:0] timer_output,
	input wire logic [CHANNELS-1:0] match_interrupt
);
	logic wv;
	logic [31:0] wa;
	logic [7:0] md;
	// Shadow of the channel 0 mode register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wv <= 1'b0;
			wa <= '0;
		end else if (hready) begin
			wv <= hsel && htrans[1] && hwrite;
			wa <= haddr;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) md <= '0;
		else if (wv && wa == ADDR_MODE[0]) md <= hwdata[7:0];
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_wr;
		hsel && hready && htrans[1] && hwrite;
	endsequence
	property p_okay;
		hresp == 1'b0;
	endproperty
	property p_rd_wait;
		s_rd |=> !hreadyout ##1 hreadyout;
	endproperty
	property p_wr_nowait;
		s_wr |=> hreadyout;
	endproperty
	property p_rd_upper;
		s_rd ##2 1'b1 |-> hrdata[31:8] == 24'h0;
	endproperty
	property p_rd_hold;
		$changed(hrdata) |-> $rose(hreadyout);
	endproperty
	property p_oe_low;
		!md[MODE_OE] && !$past(md[MODE_OE]) && !$past(md[MODE_OE], 2) |-> !timer_output[0];
	endproperty
	property p_pwm_quiet;
		md[MODE_PWM] && $past(md[MODE_PWM]) && $past(md[MODE_PWM], 2) |-> !match_interrupt[0];
	endproperty
	property p_stop_quiet;
		!md[MODE_ENABLE] && !$past(md[MODE_ENABLE]) && !$past(md[MODE_ENABLE], 2)
			|-> !match_interrupt[0];
	endproperty
	a_okay: assert property (p_okay) else $error("response not OKAY");
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	a_rd_upper: assert property (p_rd_upper) else $error("read upper bits set");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_oe_low: assert property (p_oe_low) else $error("output not low");
	a_pwm_quiet: assert property (p_pwm_quiet) else $error("match in pwm");
	a_stop_quiet: assert property (p_stop_quiet) else $error("match when stopped");
endmodule

bind timer_top timer_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .timer_output(timer_output),
	.match_interrupt(match_interrupt));

// ===== common/timer_pkg.sv
// Shared constants for the dual 8-bit timer/event counter
package timer_pkg;
	localparam int CHANNELS = 2;
	localparam int DATA_W = 8;
	localparam int SEL_W = 3;
	localparam int PRESCALE_W = 13;

	// Register indices; byte address is four times the index
	localparam logic [31:0] IDX_COUNTER_CH0 = 32'h0000FF16;
	localparam logic [31:0] IDX_COMPARE_CH0 = 32'h0000FF17;
	localparam logic [31:0] IDX_COUNTER_CH1 = 32'h0000FF1F;
	localparam logic [31:0] IDX_COMPARE_CH1 = 32'h0000FF41;
	localparam logic [31:0] IDX_SELECT_CH0 = 32'h0000FF6A;
	localparam logic [31:0] IDX_SELECT_CH1 = 32'h0000FF8C;
	localparam logic [31:0] IDX_MODE_CH0 = 32'h0000FF6B;
	localparam logic [31:0] IDX_MODE_CH1 = 32'h0000FF43;

	localparam logic [31:0] ADDR_COUNTER[CHANNELS] = '{IDX_COUNTER_CH0 * 4, IDX_COUNTER_CH1 * 4};
	localparam logic [31:0] ADDR_COMPARE[CHANNELS] = '{IDX_COMPARE_CH0 * 4, IDX_COMPARE_CH1 * 4};
	localparam logic [31:0] ADDR_SELECT[CHANNELS] = '{IDX_SELECT_CH0 * 4, IDX_SELECT_CH1 * 4};
	localparam logic [31:0] ADDR_MODE[CHANNELS] = '{IDX_MODE_CH0 * 4, IDX_MODE_CH1 * 4};

	// Reset values
	localparam logic [7:0] COUNTER_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic [2:0] SELECT_RESET = 3'h0;

	// Mode control field positions
	localparam int MODE_ENABLE = 7;
	localparam int MODE_PWM = 6;
	localparam int MODE_FF_SET = 3;
	localparam int MODE_FF_CLEAR = 2;
	localparam int MODE_INVERT = 1;
	localparam int MODE_OE = 0;

	// Count source codes
	localparam logic [2:0] SEL_EVENT_FALL = 3'h0;
	localparam logic [2:0] SEL_EVENT_RISE = 3'h1;
	localparam logic [2:0] SEL_DIV1 = 3'h2;
	localparam logic [2:0] SEL_DIV2 = 3'h3;
	localparam logic [2:0] SEL_DIVA = 3'h4;
	localparam logic [2:0] SEL_DIV64 = 3'h5;
	localparam logic [2:0] SEL_DIV256 = 3'h6;
	localparam logic [2:0] SEL_DIVB = 3'h7;

	// Divider exponents (power of two) per code
	localparam int SHIFT_DIV2 = 1;
	localparam int SHIFT_DIV64 = 6;
	localparam int SHIFT_DIV256 = 8;
	localparam int SHIFT_DIVA[CHANNELS] = '{2, 4};
	localparam int SHIFT_DIVB[CHANNELS] = '{13, 12};

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] READ_UNMAPPED = 32'h00000000;
endpackage

// ===== rtl/timer_channel.sv
// One 8-bit counter channel with compare, square wave and PWM output
`timescale 1ns/1ps
module timer_channel
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic count_tick,
	input wire logic count_enable,
	input wire logic pwm_mode,
	input wire logic invert_sel,
	input wire logic output_enable,
	input wire logic [7:0] compare_value,
	input wire logic ff_set_pulse,
	input wire logic ff_clear_pulse,
	// Status and output
	output logic [7:0] counter_value,
	output logic match_interrupt,
	output logic timer_output
);
	logic equal;
	logic output_ff;
	logic pwm_ff;

	assign equal = counter_value == compare_value;

	// Counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_value <= COUNTER_RESET;
		end else if (!count_enable) begin
			counter_value <= COUNTER_RESET;
		end else if (count_tick) begin
			if (!pwm_mode && equal) begin
				counter_value <= COUNTER_RESET;
			end else begin
				counter_value <= 8'(counter_value + 8'h01);
			end
		end
	end

	// Match request outside PWM
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_interrupt <= 1'b0;
		end else begin
			match_interrupt <= count_enable && count_tick && !pwm_mode && equal;
		end
	end

	// Timer output flip-flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_ff <= 1'b0;
		end else if (!pwm_mode && ff_clear_pulse) begin
			output_ff <= 1'b0;
		end else if (!pwm_mode && ff_set_pulse) begin
			output_ff <= 1'b1;
		end else if (count_enable && count_tick && !pwm_mode && equal && invert_sel) begin
			output_ff <= !output_ff;
		end
	end

	// PWM flip-flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_ff <= 1'b0;
		end else if (!count_enable || !pwm_mode) begin
			pwm_ff <= 1'b0;
		end else if (count_tick) begin
			if (counter_value == 8'hFF) begin
				pwm_ff <= 1'b1;
			end else if (equal) begin
				pwm_ff <= 1'b0;
			end
		end
	end

	// Pin level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_output <= 1'b0;
		end else if (!output_enable) begin
			timer_output <= 1'b0;
		end else if (pwm_mode) begin
			timer_output <= pwm_ff ^ invert_sel;
		end else begin
			timer_output <= output_ff;
		end
	end
endmodule

// ===== rtl/timer_top.sv
// Dual 8-bit timer/event counter with AHB-Lite register slave
// Behaviour
// - Read-only 8-bit up-counter advances on each selected count clock edge.
// - Counter resets to 00H.
// - Clearing the count enable bit forces the counter to zero.
// - Clear-and-start mode: counter returns to zero on compare match, continues.
// - Outside PWM, compare on each count; equal raises match interrupt.
// - PWM: output active on overflow, inactive on compare match.
// - Compare register is 8-bit read/write, any value, resets to 00H.
// - Compare register read and written as one 8-bit access.
// - Source select picks event edge or divided clock, resets to 00H.
// - Channel 0 codes: fall, rise, 1, 2, 4, 64, 256, 8192 division.
// - Channel 1 as channel 0 but code 4 is /16, code 7 /4096.
// - Each channel: interval, event count, square wave, PWM; one input, one output.
// - Enable 0 clears and holds the counter; enable 1 starts counting.
// - Mode bit 0 selects clear-and-start, 1 selects free-running PWM.
// - Output flip-flop pair: 00 hold, 01 clear, 10 set; reads zero; not PWM.
// - Output enable 0 holds pin low; invert bit toggles or selects active low.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module timer_top
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Timer pins
	input wire logic [CHANNELS-1:0] event_input,
	output logic [CHANNELS-1:0] timer_output,
	output logic [CHANNELS-1:0] match_interrupt
);
	// Bus phase state
	logic [31:0] phase_addr;
	logic phase_write;
	logic phase_read;
	logic take;
	logic [31:0] next_rdata;

	// Per-channel control state
	logic [7:0] compare_value [CHANNELS];
	logic [SEL_W-1:0] count_source_select [CHANNELS];
	logic count_enable_bit [CHANNELS];
	logic pwm_mode_select [CHANNELS];
	logic invert_or_level_select [CHANNELS];
	logic output_enable_bit [CHANNELS];
	logic output_ff_set [CHANNELS];
	logic output_ff_clear [CHANNELS];
	logic [7:0] counter_value [CHANNELS];
	logic count_tick [CHANNELS];

	// Event input synchronisers and edge history
	logic [CHANNELS-1:0] event_meta;
	logic [CHANNELS-1:0] event_sync;
	logic [CHANNELS-1:0] event_prev;

	// Free-running prescaler of the main clock
	logic [PRESCALE_W-1:0] prescale;

	function automatic logic div_tick(input logic [PRESCALE_W-1:0] p, input int k);
		logic [PRESCALE_W-1:0] m;
		m = PRESCALE_W'((32'd1 << k) - 32'd1);
		return (p & m) == m;
	endfunction

	assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_addr <= 32'h00000000;
			phase_write <= 1'b0;
			phase_read <= 1'b0;
		end else if (hready) begin
			phase_addr <= haddr;
			phase_write <= take && hwrite;
			phase_read <= take && !hwrite;
		end else begin
			phase_read <= 1'b0;
		end
	end

	// Reads take one wait state so a preceding write is already stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
		end else begin
			hreadyout <= !(take && !hwrite);
		end
	end

	// Response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
		end
	end

	// Read data mux
	always_comb begin
		next_rdata = READ_UNMAPPED;
		for (int c = 0; c < CHANNELS; c++) begin
			if (phase_addr == ADDR_COUNTER[c]) begin
				next_rdata = {24'h000000, counter_value[c]};
			end
			if (phase_addr == ADDR_COMPARE[c]) begin
				next_rdata = {24'h000000, compare_value[c]};
			end
			if (phase_addr == ADDR_SELECT[c]) begin
				next_rdata = {29'h00000000, count_source_select[c]};
			end
			if (phase_addr == ADDR_MODE[c]) begin
				next_rdata = 32'h00000000;
				next_rdata[MODE_ENABLE] = count_enable_bit[c];
				next_rdata[MODE_PWM] = pwm_mode_select[c];
				next_rdata[MODE_INVERT] = invert_or_level_select[c];
				next_rdata[MODE_OE] = output_enable_bit[c];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (phase_read) begin
			hrdata <= next_rdata;
		end
	end

	// Prescaler
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale <= '0;
		end else begin
			prescale <= PRESCALE_W'(prescale + 1'b1);
		end
	end

	// Event synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			event_meta <= '0;
			event_sync <= '0;
			event_prev <= '0;
		end else begin
			event_meta <= event_input;
			event_sync <= event_meta;
			event_prev <= event_sync;
		end
	end

	for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
		logic wr_compare;
		logic wr_select;
		logic wr_mode;

		assign wr_compare = phase_write && phase_addr == ADDR_COMPARE[g];
		assign wr_select = phase_write && phase_addr == ADDR_SELECT[g];
		assign wr_mode = phase_write && phase_addr == ADDR_MODE[g];

		// Compare register
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				compare_value[g] <= COMPARE_RESET;
			end else if (wr_compare) begin
				compare_value[g] <= hwdata[7:0];
			end
		end

		// Count source select; upper bits are not stored
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				count_source_select[g] <= SELECT_RESET;
			end else if (wr_select) begin
				count_source_select[g] <= hwdata[SEL_W-1:0];
			end
		end

		// Mode control
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				count_enable_bit[g] <= 1'b0;
				pwm_mode_select[g] <= 1'b0;
				invert_or_level_select[g] <= 1'b0;
				output_enable_bit[g] <= 1'b0;
			end else if (wr_mode) begin
				count_enable_bit[g] <= hwdata[MODE_ENABLE];
				pwm_mode_select[g] <= hwdata[MODE_PWM];
				invert_or_level_select[g] <= hwdata[MODE_INVERT];
				output_enable_bit[g] <= hwdata[MODE_OE];
			end
		end

		// Write-only set/clear pair as one-cycle pulses; 11 does nothing
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				output_ff_set[g] <= 1'b0;
				output_ff_clear[g] <= 1'b0;
			end else begin
				output_ff_set[g] <= wr_mode && hwdata[MODE_FF_SET] && !hwdata[MODE_FF_CLEAR];
				output_ff_clear[g] <= wr_mode && !hwdata[MODE_FF_SET] && hwdata[MODE_FF_CLEAR];
			end
		end

		// Count tick source
		always_comb begin
			unique case (count_source_select[g])
				SEL_EVENT_FALL: count_tick[g] = event_prev[g] && !event_sync[g];
				SEL_EVENT_RISE: count_tick[g] = !event_prev[g] && event_sync[g];
				SEL_DIV1: count_tick[g] = 1'b1;
				SEL_DIV2: count_tick[g] = div_tick(prescale, SHIFT_DIV2);
				SEL_DIVA: count_tick[g] = div_tick(prescale, SHIFT_DIVA[g]);
				SEL_DIV64: count_tick[g] = div_tick(prescale, SHIFT_DIV64);
				SEL_DIV256: count_tick[g] = div_tick(prescale, SHIFT_DIV256);
				SEL_DIVB: count_tick[g] = div_tick(prescale, SHIFT_DIVB[g]);
			endcase
		end

		// Channel core
		timer_channel u_channel (
			.hclk(hclk),
			.hresetn(hresetn),
			.count_tick(count_tick[g]),
			.count_enable(count_enable_bit[g]),
			.pwm_mode(pwm_mode_select[g]),
			.invert_sel(invert_or_level_select[g]),
			.output_enable(output_enable_bit[g]),
			.compare_value(compare_value[g]),
			.ff_set_pulse(output_ff_set[g]),
			.ff_clear_pulse(output_ff_clear[g]),
			.counter_value(counter_value[g]),
			.match_interrupt(match_interrupt[g]),
			.timer_output(timer_output[g])
		);
	end
endmodule
